// >>> inc/tpsf_pkg.sv
// power-state sequencer constants: states, timing figures and derived cycle counts
// assumes a single 40 MHz clock drives all sequencer logic
`default_nettype none

package tpsf_pkg;

  // ****************************************************************
  // clock
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;

  // ****************************************************************
  // sequence budgets
  // ****************************************************************
  localparam int FIRST_POWERUP_NS = 1_250_000;
  localparam int WAKEUP_NS        = 1_060_000;
  localparam int GO2SLP_NS        = 400_000;
  localparam int FIRST_POWERUP_CYC = FIRST_POWERUP_NS / CLK_PERIOD_NS;
  localparam int WAKEUP_CYC        = WAKEUP_NS / CLK_PERIOD_NS;
  localparam int GO2SLP_CYC        = GO2SLP_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // wake detection and pin timing
  // ****************************************************************
  localparam int WAKE_PULSES      = 8;
  localparam int WAKE_WIN_MIN_US  = 150;
  localparam int WAKE_WIN_MAX_US  = 630;
  // shortest window keeps detection inside the allowed span
  localparam int WAKE_WIN_CYC     = (WAKE_WIN_MIN_US * 1000) / CLK_PERIOD_NS;
  localparam int DEGLITCH_NS      = 2000;
  localparam int DEGLITCH_CYC     = DEGLITCH_NS / CLK_PERIOD_NS;
  localparam int PULLDOWN_MS      = 800;
  localparam int PULLDOWN_CYC     = (PULLDOWN_MS * 1_000_000) / CLK_PERIOD_NS;
  localparam int STBY_DIV_DEFAULT = 40;

  // ****************************************************************
  // configuration
  // ****************************************************************
  localparam int          RATE_W       = 4;
  localparam logic [3:0]  RATE_SLOWEST = 4'h0;

  typedef enum logic [2:0] {
    TPSF_RESET,
    TPSF_STANDBY,
    TPSF_REG_EN,
    TPSF_TRIM,
    TPSF_NORMAL,
    TPSF_REG_DIS
  } tpsf_state_t;

endpackage : tpsf_pkg

`default_nettype wire

// >>> logic/tpsf_sequencer.sv
// transceiver power-state sequencer: reset, stand-by, regulators up, trim/latch,
// normal, regulators down, with pin and link wake-up and pin pull-down signalling
// assumes all inputs synchronous to clock; main_por and standby_por high = in reset;
// the stand-by oscillator is modelled as an enable pulse every STBY_DIV clocks
//
// Behaviour
// - first power-up walks reset, stand-by, regulators up, trim, normal within 1.25 ms
// - wake-up walks stand-by, regulators up, normal; link ready within 1.06 ms
// - go-to-sleep walks normal, regulators down, stand-by within 400 us
// - while stand-by supply reset is asserted, hold reset state, do nothing
// - leave reset for stand-by only once stand-by reset releases
// - stand-by without first boot done goes straight to regulators up
// - stand-by with first boot done waits for a wake-up source
// - pin release, filtered by one stand-by tick, is a wake-up source
// - eight link pulses within the timeout window are a wake-up source
// - regulators up enables supplies, ignores pins and link, never aborts
// - main reset release leaves regulators up: trim if first boot, else normal
// - trim loads OTP and latches master, phase, polarity and clock rate
// - clock-rate comparators self-tested first; failure stores slowest rate zero
// - latched configuration kept until stand-by reset, cleared only by it
// - trim ignores activity; on completion sets first boot done, enters normal
// - after link wake-up, normal drives pin low for the pull-down interval
// - interval end releases pin and unmasks it; host must hold it low
// - after pin wake-up, normal watches the deglitched pin at once
// - in normal the pin is sampled through a clocked deglitch filter
// - deglitched high pin in normal triggers go-to-sleep
// - regulators down drops enables; main reset assertion moves to stand-by
// - regulators down ignores all pins and cannot be aborted
// - deglitch is an up counter cleared while pin reads low
// - pull-down interval is 800 ms from main reset release
`default_nettype none

module tpsf_sequencer
  import tpsf_pkg::*;
#(
  parameter int STBY_DIV     = STBY_DIV_DEFAULT,
  parameter int WAKE_WIN     = WAKE_WIN_CYC,
  parameter int PULLDOWN_LEN = PULLDOWN_CYC
) (
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              standby_por,
  input  wire logic              main_por,
  input  wire logic              sleep_request_pin_in,
  input  wire logic              link_pulse,
  input  wire logic              master_select_in,
  input  wire logic              cpha_in,
  input  wire logic              cpol_in,
  input  wire logic [RATE_W-1:0] sck_rate_code,
  input  wire logic              otp_done,
  input  wire logic              rate_bist_done,
  input  wire logic              rate_bist_pass,
  output tpsf_state_t            power_state,
  output logic                   main_reg_en,
  output logic                   main_osc_en,
  output logic                   otp_load_req,
  output logic                   rate_bist_req,
  output logic                   master_select,
  output logic                   cpha,
  output logic                   cpol,
  output logic [RATE_W-1:0]      sck_rate_select,
  output logic                   first_boot_done,
  output logic                   link_ready,
  output logic                   sleep_request_pin_out,
  output logic                   sleep_request_pin_oe
);

  localparam int DIV_W = $clog2(STBY_DIV + 1);
  localparam int WIN_W = $clog2(WAKE_WIN + 1);
  localparam int PD_W  = $clog2(PULLDOWN_LEN + 1);
  localparam int DG_W  = $clog2(DEGLITCH_CYC + 1);
  localparam int PC_W  = $clog2(WAKE_PULSES + 1);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************************************
  // stand-by oscillator tick
  // ****************************************************************
  logic [DIV_W-1:0] div_cnt;
  logic             stby_tick;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt   <= '0;
      stby_tick <= 1'b0;
    end else if (div_cnt == DIV_W'(STBY_DIV - 1)) begin
      div_cnt   <= '0;
      stby_tick <= 1'b1;
    end else begin
      div_cnt   <= div_cnt + 1'b1;
      stby_tick <= 1'b0;
    end
  end

  // ****************************************************************
  // stand-by wake sources
  // ****************************************************************
  logic [2:0]       pin_hist;
  logic             pin_wake;
  logic             link_wake;
  logic [PC_W-1:0]  pulse_cnt;
  logic [WIN_W-1:0] win_cnt;
  logic             in_standby;

  assign in_standby = (power_state == TPSF_STANDBY);

  // pin release: low tick then two high ticks
  // pin wake latched on stand-by ticks only; link pulses counted on every clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_hist <= 3'h7;
      pin_wake <= 1'b0;
    end else if (!in_standby) begin
      pin_hist <= 3'h7;
      pin_wake <= 1'b0;
    end else if (stby_tick) begin
      pin_hist <= {pin_hist[1:0], sleep_request_pin_in};
      if (pin_hist[1:0] == 2'h1 && sleep_request_pin_in)
        pin_wake <= 1'b1;
    end
  end

  // pulse count inside window opened by first pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt <= '0;
      win_cnt   <= '0;
      link_wake <= 1'b0;
    end else if (!in_standby) begin
      pulse_cnt <= '0;
      win_cnt   <= '0;
      link_wake <= 1'b0;
    end else if (pulse_cnt != '0 && win_cnt == WIN_W'(WAKE_WIN - 1) && !link_wake) begin
      pulse_cnt <= '0;
      win_cnt   <= '0;
    end else begin
      if (pulse_cnt != '0)
        win_cnt <= win_cnt + 1'b1;
      if (link_pulse && !link_wake) begin
        pulse_cnt <= pulse_cnt + 1'b1;
        if (pulse_cnt == PC_W'(WAKE_PULSES - 1))
          link_wake <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // state machine
  // ****************************************************************
  logic sleep_trig;
  logic wake_by_link;

  // stand-by supply reset forces and releases the reset state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_state <= TPSF_RESET;
    end else if (standby_por) begin
      power_state <= TPSF_RESET;
    end else begin
      case (power_state)
        TPSF_RESET:   power_state <= TPSF_STANDBY;
        // boot at once, otherwise wait for a wake source
        TPSF_STANDBY: if (!first_boot_done || pin_wake || link_wake)
                        power_state <= TPSF_REG_EN;
        // only main reset release leaves this state
        TPSF_REG_EN:  if (!main_por)
                        power_state <= first_boot_done ? TPSF_NORMAL : TPSF_TRIM;
        // trim ends on its own completion only
        TPSF_TRIM:    if (otp_done && rate_bist_done)
                        power_state <= TPSF_NORMAL;
        TPSF_NORMAL:  if (sleep_trig)
                        power_state <= TPSF_REG_DIS;
        TPSF_REG_DIS: if (main_por)
                        power_state <= TPSF_STANDBY;
        default:      power_state <= TPSF_RESET;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wake_by_link <= 1'b0;
    end else if (in_standby && first_boot_done && !standby_por) begin
      wake_by_link <= link_wake && !pin_wake;
    end
  end

  // ****************************************************************
  // supply enables and trim requests
  // ****************************************************************
  // enables up from regulators up to normal, down otherwise
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_reg_en   <= 1'b0;
      main_osc_en   <= 1'b0;
      otp_load_req  <= 1'b0;
      rate_bist_req <= 1'b0;
      link_ready    <= 1'b0;
    end else begin
      main_reg_en   <= power_state inside {TPSF_REG_EN, TPSF_TRIM, TPSF_NORMAL};
      main_osc_en   <= power_state inside {TPSF_REG_EN, TPSF_TRIM, TPSF_NORMAL};
      otp_load_req  <= power_state == TPSF_TRIM && !standby_por;
      rate_bist_req <= power_state == TPSF_TRIM && !standby_por;
      link_ready    <= power_state == TPSF_NORMAL && !standby_por;
    end
  end

  // ****************************************************************
  // stand-by configuration registers
  // ****************************************************************
  // only stand-by reset clears these
  // latch at trim completion, slowest rate on self-test failure
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      master_select   <= 1'b0;
      cpha            <= 1'b0;
      cpol            <= 1'b0;
      sck_rate_select <= RATE_SLOWEST;
      first_boot_done <= 1'b0;
    end else if (standby_por) begin
      master_select   <= 1'b0;
      cpha            <= 1'b0;
      cpol            <= 1'b0;
      sck_rate_select <= RATE_SLOWEST;
      first_boot_done <= 1'b0;
    end else if (power_state == TPSF_TRIM && otp_done && rate_bist_done) begin
      master_select   <= master_select_in;
      cpha            <= cpha_in;
      cpol            <= cpol_in;
      sck_rate_select <= rate_bist_pass ? sck_rate_code : RATE_SLOWEST;
      first_boot_done <= 1'b1;
    end
  end

  // ****************************************************************
  // pin pull-down and deglitch (main logic)
  // ****************************************************************
  logic [PD_W-1:0] pd_cnt;
  logic [DG_W-1:0] dg_cnt;

  // pull-down from main reset release after a link wake-up
  // released at interval end, which also unmasks the filter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pd_cnt               <= '0;
      sleep_request_pin_oe <= 1'b0;
    end else if (main_por || standby_por) begin
      pd_cnt               <= '0;
      sleep_request_pin_oe <= 1'b0;
    end else if (power_state == TPSF_REG_EN && wake_by_link && first_boot_done) begin
      pd_cnt               <= '0;
      sleep_request_pin_oe <= 1'b1;
    end else if (sleep_request_pin_oe) begin
      pd_cnt <= pd_cnt + 1'b1;
      if (pd_cnt == PD_W'(PULLDOWN_LEN - 1))
        sleep_request_pin_oe <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      sleep_request_pin_out <= 1'b0;
    else
      sleep_request_pin_out <= 1'b0;
  end

  // up/reset counter, live as soon as normal is reached
  // masked while driving the pin, since our own pull-down would read low anyway
  assign sleep_trig = (power_state == TPSF_NORMAL) && !sleep_request_pin_oe &&
                      sleep_request_pin_in && (dg_cnt == DG_W'(DEGLITCH_CYC - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      dg_cnt <= '0;
    else if (power_state != TPSF_NORMAL || sleep_request_pin_oe || !sleep_request_pin_in)
      dg_cnt <= '0;
    else if (dg_cnt != DG_W'(DEGLITCH_CYC - 1))
      dg_cnt <= dg_cnt + 1'b1;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  reset_hold_a: assert property (standby_por |=> power_state == TPSF_RESET)
    else $error("stand-by reset did not hold reset state");
  boot_start_a: assert property (power_state == TPSF_STANDBY && !first_boot_done &&
    !standby_por |=> power_state == TPSF_REG_EN)
    else $error("first boot did not start regulators");
  stby_wait_a: assert property (power_state == TPSF_STANDBY && first_boot_done &&
    !pin_wake && !link_wake && !standby_por |=> power_state == TPSF_STANDBY)
    else $error("left stand-by without wake source");
  regen_exit_a: assert property (power_state == TPSF_REG_EN && !main_por && !standby_por
    |=> power_state == (first_boot_done ? TPSF_NORMAL : TPSF_TRIM))
    else $error("wrong exit from regulators enabling");
  bist_fail_a: assert property (power_state == TPSF_TRIM && otp_done && rate_bist_done &&
    !rate_bist_pass && !standby_por |=> sck_rate_select == RATE_SLOWEST &&
    first_boot_done && power_state == TPSF_NORMAL)
    else $error("failed self-test did not store slowest rate");
  pd_hold_a: assert property (power_state == TPSF_NORMAL && sleep_request_pin_oe &&
    !standby_por |=> power_state == TPSF_NORMAL)
    else $error("pin input not masked during pull-down");
  sleep_go_a: assert property (sleep_trig && !standby_por
    |=> power_state == TPSF_REG_DIS ##1 !main_reg_en && !main_osc_en)
    else $error("go-to-sleep trigger ignored");
  dg_clear_a: assert property (!sleep_request_pin_in |=> dg_cnt == '0)
    else $error("deglitch counter not cleared on low pin");
  regdis_stay_a: assert property (power_state == TPSF_REG_DIS && !main_por &&
    !standby_por |=> power_state == TPSF_REG_DIS)
    else $error("sleep sequence aborted");

  first_boot_c: cover property (power_state == TPSF_TRIM ##1 power_state == TPSF_NORMAL);
  link_wake_c:  cover property (link_wake ##[1:4] power_state == TPSF_REG_EN);
  pin_wake_c:   cover property (pin_wake ##[1:4] power_state == TPSF_REG_EN);
  sleep_c:      cover property (power_state == TPSF_REG_DIS ##1 power_state == TPSF_STANDBY);

endmodule : tpsf_sequencer

`default_nettype wire

// >>> verif/tpsf_host_model.sv
// host and main supply stand-in facing the power-state sequencer
// assumes the board pulls the sleep/wake pin up and the bench commands the host
`default_nettype none

module tpsf_host_model (
  input  wire logic clock,
  input  wire logic host_hold_low,
  input  wire logic sleep_request_pin_oe,
  input  wire logic main_reg_en,
  output logic      pin_level,
  output logic      main_por
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********
  // open-drain wire and main regulator
  // ********
  logic [3:0] ramp = 4'h0;

  // host holds pin low to stay awake
  assign pin_level = ~(host_hold_low | sleep_request_pin_oe);

  // regulator needs a few cycles before main reset lifts, so the wait is not trivial
  always_ff @(posedge clock) begin
    if (!main_reg_en) begin
      ramp <= 4'h0;
    end else if (ramp != 4'h7) begin
      ramp <= ramp + 4'h1;
    end
  end

  assign main_por = (ramp != 4'h7);
endmodule : tpsf_host_model

`default_nettype wire

// >>> verif/tb.sv
// self-checking bench: first boot, sleep, pin wake, link wake, stand-by reset
// assumes the host model stands for the pin pull-up, the host and the main supply
`default_nettype none

module tb;
  import tpsf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ********
  // stimulus and wiring
  // ********
  localparam int PD_LEN = 100;
  logic        clock          = 1'b0;
  logic        arst_n         = 1'b0;
  logic        standby_por    = 1'b1;
  logic        host_low       = 1'b1;
  logic        link_pulse     = 1'b0;
  logic        otp_done       = 1'b0;
  logic        rate_bist_done = 1'b0;
  logic        rate_bist_pass = 1'b0;
  logic [2:0]  strap_cfg      = 3'h0;
  logic [3:0]  strap_code     = 4'h0;
  logic        pin_level;
  logic        main_por;
  tpsf_state_t power_state;
  logic        main_reg_en;
  logic        main_osc_en;
  logic        otp_load_req;
  logic        rate_bist_req;
  logic        master_select;
  logic        cpha;
  logic        cpol;
  logic [3:0]  sck_rate_select;
  logic        first_boot_done;
  logic        link_ready;
  logic        pin_out;
  logic        pin_oe;
  int          err_count   = 0;
  int          comparisons = 0;

  always #12.5 clock = ~clock;

  tpsf_sequencer #(.STBY_DIV(4), .WAKE_WIN(50), .PULLDOWN_LEN(PD_LEN)) i_dut (
    .clock(clock), .arst_n(arst_n), .standby_por(standby_por), .main_por(main_por),
    .sleep_request_pin_in(pin_level), .link_pulse(link_pulse),
    .master_select_in(strap_cfg[2]), .cpha_in(strap_cfg[1]), .cpol_in(strap_cfg[0]),
    .sck_rate_code(strap_code),
    .otp_done(otp_done), .rate_bist_done(rate_bist_done), .rate_bist_pass(rate_bist_pass),
    .power_state(power_state), .main_reg_en(main_reg_en), .main_osc_en(main_osc_en),
    .otp_load_req(otp_load_req), .rate_bist_req(rate_bist_req),
    .master_select(master_select), .cpha(cpha), .cpol(cpol),
    .sck_rate_select(sck_rate_select), .first_boot_done(first_boot_done),
    .link_ready(link_ready), .sleep_request_pin_out(pin_out),
    .sleep_request_pin_oe(pin_oe));

  tpsf_host_model i_host (
    .clock(clock), .host_hold_low(host_low), .sleep_request_pin_oe(pin_oe),
    .main_reg_en(main_reg_en), .pin_level(pin_level), .main_por(main_por));

  // ********
  // shared tasks
  // ********
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // inputs always move 2 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : cyc

  task automatic wait_st(input tpsf_state_t s, input int lim);
    int i;
    i = 0;
    while (power_state !== s && i < lim) begin
      cyc(1);
      i++;
    end
    check(power_state, s);
  endtask : wait_st

  task automatic pulses(input int n);
    repeat (n) begin
      link_pulse = 1'b1;
      cyc(1);
      link_pulse = 1'b0;
      cyc(1);
    end
  endtask : pulses

  task automatic boot(input logic pass, input logic [2:0] cfg, input logic [3:0] code,
                      input logic [3:0] rate);
    strap_cfg = cfg;
    strap_code = code;
    standby_por = 1'b0;
    cyc(1);
    check(power_state, TPSF_STANDBY);
    cyc(1);
    check(power_state, TPSF_REG_EN);
    cyc(2);
    check({main_reg_en, main_osc_en}, 2'b11);
    wait_st(TPSF_TRIM, 20);
    pulses(2);
    check({otp_load_req, rate_bist_req}, 2'b11);
    rate_bist_pass = pass;
    otp_done = 1'b1;
    rate_bist_done = 1'b1;
    wait_st(TPSF_NORMAL, 5);
    check({master_select, cpha, cpol, sck_rate_select}, {cfg, rate});
    check(first_boot_done, 1'b1);
    otp_done = 1'b0;
    rate_bist_done = 1'b0;
    cyc(2);
    check(link_ready, 1'b1);
    $display("test boot done");
  endtask : boot

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // ********
  // tests
  // ********
  initial begin
    cyc(2);
    arst_n = 1'b1;
    cyc(4);
    check(power_state, TPSF_RESET);
    boot(1'b1, 3'b101, 4'h3, 4'h3);
    // a high shorter than the deglitch count must not sleep
    host_low = 1'b0;
    cyc(DEGLITCH_CYC - 4);
    host_low = 1'b1;
    cyc(4);
    check(power_state, TPSF_NORMAL);
    host_low = 1'b0;
    wait_st(TPSF_REG_DIS, DEGLITCH_CYC + 4);
    host_low = 1'b1;
    cyc(2);
    check({main_reg_en, main_osc_en, link_ready}, 3'b000);
    wait_st(TPSF_STANDBY, GO2SLP_CYC);
    cyc(40);
    check(power_state, TPSF_STANDBY);
    check({first_boot_done, sck_rate_select}, 5'h13);
    $display("test sleep done");
    host_low = 1'b0;
    wait_st(TPSF_REG_EN, 20);
    host_low = 1'b1;
    wait_st(TPSF_NORMAL, WAKEUP_CYC);
    check(pin_oe, 1'b0);
    host_low = 1'b0;
    wait_st(TPSF_REG_DIS, DEGLITCH_CYC + 4);
    wait_st(TPSF_STANDBY, GO2SLP_CYC);
    $display("test pin wake done");
    pulses(7);
    cyc(60);
    check(power_state, TPSF_STANDBY);
    pulses(8);
    wait_st(TPSF_REG_EN, 10);
    wait_st(TPSF_NORMAL, WAKEUP_CYC);
    cyc(2);
    check(pin_oe, 1'b1);
    check(pin_level, 1'b0);
    cyc(PD_LEN - 8);
    check({pin_oe, power_state}, {1'b1, TPSF_NORMAL});
    host_low = 1'b1;
    cyc(12);
    check({pin_oe, pin_out, power_state}, {2'b00, TPSF_NORMAL});
    host_low = 1'b0;
    wait_st(TPSF_REG_DIS, DEGLITCH_CYC + 4);
    wait_st(TPSF_STANDBY, GO2SLP_CYC);
    $display("test link wake done");
    standby_por = 1'b1;
    host_low = 1'b1;
    cyc(2);
    check({power_state, first_boot_done, master_select, cpha, cpol, sck_rate_select},
          {TPSF_RESET, 8'h00});
    // failed self-test must store the slowest rate, whatever the comparator code
    boot(1'b0, 3'b010, 4'h7, 4'h0);
    final_report();
  end

  // whole run is about 650 cycles
  initial begin
    #(5000 * 25);
    err_count++;
    final_report();
  end
endmodule : tb

`default_nettype wire
